// ### fbd_alu_if.sv
// operand and result bundle between the sequencer and the decoder
`timescale 1ns/1ps
`default_nettype none
interface fbd_alu_if;
  import fbd_pkg::*;
  logic [INSTR_W-1:0] instr;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] fileVal;
  logic carryIn;
  logic [DATA_W-1:0] result;
  logic toAcc, toFile, setC, newC, setDc, newDc, setZ;
  logic skip, jump, call, ret, retIrq, wdtClr, sleep;
  modport seq (output instr, acc, fileVal, carryIn, input result, toAcc, toFile,
    setC, newC, setDc, newDc, setZ, skip, jump, call, ret, retIrq, wdtClr, sleep);
  modport alu (input instr, acc, fileVal, carryIn, output result, toAcc, toFile,
    setC, newC, setDc, newDc, setZ, skip, jump, call, ret, retIrq, wdtClr, sleep);
endinterface
`default_nettype wire

// ### fbd_core.sv
// instruction sequencer, file registers and avalon-mm register slave
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module fbd_core
  import fbd_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // program memory
  output logic [PC_W-1:0] progAddr,
  input wire logic [INSTR_W-1:0] progWord,
  // io port
  input wire logic [DATA_W-1:0] portIn,
  output logic [DATA_W-1:0] portOut,
  // core events
  output logic wdtClear,
  output logic standby
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  fbd_phase_type phase_q;
  logic [INSTR_W-1:0] instr_q;
  logic flush_q;
  logic [DATA_W-1:0] fileRd_q;
  logic [DATA_W-1:0] acc_q;
  logic carry_q, digitCarry_q, zero_q;
  logic timeoutStatusBit_q, powerdownStatusBit_q;
  logic irqEn_q, standby_q, wdtClr_q;
  logic [PC_W-1:0] pc_q;
  logic [SP_W-1:0] sp_q;
  logic [PC_W-1:0] stackMem [STACK_DEPTH];
  logic [DATA_W-1:0] fileMem [FILE_DEPTH];
  logic [DATA_W-1:0] timer_q, portLatch_q;
  logic [PSC_W-1:0] presc_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic ack_q;
  logic [31:0] readdata_q;
  logic running, commit, fetch, wrFile, wrTimer, wrPort, wrRam;
  logic busReq, regWr, wake, timerTick, flushReq;
  logic [FADDR_W-1:0] fileAddr;
  logic [DATA_W-1:0] readVal;
  logic [STAT_W-1:0] statVec;
  logic [31:0] regMux;
  logic [SP_W-1:0] spPrev;

  fbd_alu_if alu ();

  fbd_decode u_decode (
    .bus(alu)
  );

  assign alu.instr = instr_q;
  assign alu.acc = acc_q;
  assign alu.fileVal = fileRd_q;
  assign alu.carryIn = carry_q;

  assign fileAddr = instr_q[FADDR_W-1:0];
  assign running = ctrl_q[CTRL_RUN] && !standby_q;
  assign fetch = (phase_q == PH_FETCH) && running;
  assign commit = (phase_q == PH_WRITE);
  assign wrFile = commit && alu.toFile;
  assign wrTimer = wrFile && (fileAddr == FA_TIMER);
  assign wrPort = wrFile && (fileAddr == FA_PORT);
  assign wrRam = wrFile && !wrTimer && !wrPort;
  assign flushReq = alu.skip || alu.jump || alu.ret;
  assign spPrev = sp_q - SP_W'(1);

  // the core only waits in the fetch phase, so a started cycle always completes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= PH_FETCH;
    end else begin
      case (phase_q)
        PH_FETCH: begin
          if (running) begin
            phase_q <= PH_READ;
          end
        end
        PH_READ: phase_q <= PH_MODIFY;
        PH_MODIFY: phase_q <= PH_WRITE;
        PH_WRITE: phase_q <= PH_FETCH;
        default: phase_q <= PH_FETCH;
      endcase
    end
  end

  // a discarded word is replaced by the no-operation word, so it has no effect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      instr_q <= NOP_WORD;
      flush_q <= 1'b0;
    end else if (fetch) begin
      instr_q <= flush_q ? NOP_WORD : progWord;
      flush_q <= 1'b0;
    end else if (commit) begin
      flush_q <= flushReq;
    end
  end

  // port reads look at the pins, so read-modify-write may alter input bits
  always_comb begin
    case (fileAddr)
      FA_TIMER: readVal = timer_q;
      FA_PORT: readVal = portIn;
      default: readVal = fileMem[fileAddr];
    endcase
  end

  // every instruction reads its file operand, even pure writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fileRd_q <= BYTE_ZERO;
    end else if (phase_q == PH_READ) begin
      fileRd_q <= readVal;
    end
  end

  always_ff @(posedge clk) begin
    if (wrRam) begin
      fileMem[fileAddr] <= alu.result;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_q <= BYTE_ZERO;
    end else if (commit && alu.toAcc) begin
      acc_q <= alu.result;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      portLatch_q <= BYTE_ZERO;
    end else if (wrPort) begin
      portLatch_q <= alu.result;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      carry_q <= 1'b0;
      digitCarry_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (commit) begin
      if (alu.setC) begin
        carry_q <= alu.newC;
      end
      if (alu.setDc) begin
        digitCarry_q <= alu.newDc;
      end
      if (alu.setZ) begin
        zero_q <= (alu.result == BYTE_ZERO);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timeoutStatusBit_q <= STAT_TO_RST;
      powerdownStatusBit_q <= STAT_PD_RST;
    end else if (commit && alu.wdtClr) begin
      timeoutStatusBit_q <= 1'b1;
      powerdownStatusBit_q <= 1'b1;
    end else if (commit && alu.sleep) begin
      timeoutStatusBit_q <= 1'b1;
      powerdownStatusBit_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdtClr_q <= 1'b0;
    end else begin
      wdtClr_q <= commit && alu.wdtClr;
    end
  end

  // a sleep committed in the same cycle as a wake write keeps the core asleep
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standby_q <= 1'b0;
    end else if (commit && alu.sleep) begin
      standby_q <= 1'b1;
    end else if (wake) begin
      standby_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqEn_q <= 1'b0;
    end else if (commit && alu.retIrq) begin
      irqEn_q <= 1'b1;
    end
  end

  // pc advances at fetch but holds in a branch's no-operation cycle, so the target runs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= '0;
    end else if (fetch) begin
      pc_q <= (flush_q && (alu.jump || alu.ret)) ? pc_q : pc_q + PC_W'(1);
    end else if (commit && alu.jump) begin
      pc_q <= instr_q[JUMP_W-1:0];
    end else if (commit && alu.ret) begin
      pc_q <= stackMem[spPrev];
    end
  end

  // the stack wraps silently; overflow loses the oldest return address
  always_ff @(posedge clk) begin
    if (commit && alu.call) begin
      stackMem[sp_q] <= pc_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_q <= '0;
    end else if (commit && alu.call) begin
      sp_q <= sp_q + SP_W'(1);
    end else if (commit && alu.ret) begin
      sp_q <= spPrev;
    end
  end

  // timer counts instruction cycles, through the prescaler when assigned
  assign timerTick = commit && (!ctrl_q[CTRL_PSA] || (presc_q == PSC_MAX));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc_q <= PSC_RST;
    end else if (wrTimer && ctrl_q[CTRL_PSA]) begin
      presc_q <= PSC_RST;
    end else if (commit) begin
      presc_q <= presc_q + PSC_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_q <= BYTE_ZERO;
    end else if (wrTimer) begin
      timer_q <= alu.result;
    end else if (timerTick) begin
      timer_q <= timer_q + BYTE_ONE;
    end
  end

  // bus slave: every access waits exactly one cycle
  assign busReq = read || write;
  assign waitrequest = busReq && !ack_q;
  assign regWr = write && ack_q;
  assign wake = regWr && (address == REG_CTRL) && writedata[CTRL_WAKE];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= busReq && !ack_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
    end else if (regWr && (address == REG_CTRL)) begin
      ctrl_q <= writedata[CTRL_W-1:0];
    end
  end

  always_comb begin
    statVec = '0;
    statVec[ST_C] = carry_q;
    statVec[ST_DC] = digitCarry_q;
    statVec[ST_Z] = zero_q;
    statVec[ST_TO] = timeoutStatusBit_q;
    statVec[ST_PD] = powerdownStatusBit_q;
    statVec[ST_STBY] = standby_q;
    statVec[ST_IRQEN] = irqEn_q;
  end

  always_comb begin
    case (address)
      REG_CTRL: regMux = 32'(ctrl_q);
      REG_STAT: regMux = 32'(statVec);
      REG_ACC: regMux = 32'(acc_q);
      REG_PC: regMux = 32'(pc_q);
      REG_TIMER: regMux = 32'({presc_q, timer_q});
      REG_INSTR: regMux = 32'(instr_q);
      default: regMux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata_q <= '0;
    end else if (read && !ack_q) begin
      readdata_q <= regMux;
    end
  end

  assign readdata = readdata_q;
  assign progAddr = pc_q;
  assign portOut = portLatch_q;
  assign wdtClear = wdtClr_q;
  assign standby = standby_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  phase_order_a: assert property (
    (phase_q == PH_READ) |=> (phase_q == PH_MODIFY) ##1 (phase_q == PH_WRITE)
      ##1 (phase_q == PH_FETCH))
    else $error("instruction cycle is not four periods");

  flush_nop_a: assert property (
    (commit && flushReq) ##1 fetch |=> (instr_q == NOP_WORD))
    else $error("second cycle of a branch or skip is not a no-operation");

  dest_route_a: assert property (
    (commit && (instr_q[GRP_MSB:GRP_LSB] == GRP_BYTE)
      && (instr_q[OP_MSB:OP_LSB] != OP_CTRL))
      |-> (alu.toFile == instr_q[DEST_BIT]) && (alu.toAcc != instr_q[DEST_BIT]))
    else $error("destination select misrouted");

  zero_flag_a: assert property (
    (commit && alu.setZ) |=> (zero_q == ($past(alu.result) == BYTE_ZERO)))
    else $error("zero flag does not match result");

  rmw_read_a: assert property (
    wrFile |-> ($past(phase_q, 2) == PH_READ))
    else $error("file written without a preceding read");

  skip_cycle_a: assert property (
    (commit && alu.skip) |=> flush_q && (phase_q == PH_FETCH))
    else $error("skip did not schedule a second cycle");

  pin_sample_a: assert property (
    (phase_q == PH_READ) && (fileAddr == FA_PORT) |=> (fileRd_q == $past(portIn)))
    else $error("port read did not sample the pins");

  presc_clear_a: assert property (
    (wrTimer && ctrl_q[CTRL_PSA]) |=> (presc_q == PSC_RST) && (timer_q == $past(alu.result)))
    else $error("timer write did not clear the prescaler");

  sleep_status_a: assert property (
    (commit && alu.sleep) |=> standby_q && !powerdownStatusBit_q && timeoutStatusBit_q
      ##1 (phase_q == PH_FETCH))
    else $error("standby entry or status bits wrong");

  watchdog_op_a: assert property (
    (commit && alu.wdtClr) |=> wdtClear && timeoutStatusBit_q && powerdownStatusBit_q
      ##1 !wdtClear)
    else $error("watchdog clear pulse or status bits wrong");

  bus_wait_a: assert property (
    (busReq && !ack_q) |-> waitrequest ##1 !waitrequest)
    else $error("bus access not answered after one wait cycle");
endmodule
`default_nettype wire

// ### fbd_decode.sv
// combinational instruction decoder and arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module fbd_decode
  import fbd_pkg::*;
(
  // operands in, results out
  fbd_alu_if.alu bus
);
  logic [1:0] grp;
  logic [3:0] op;
  logic [1:0] sub;
  logic [2:0] bsel;
  logic [7:0] lit, src, addB, mask;
  logic isSub;
  logic [8:0] sum;
  logic [4:0] half;

  assign grp = bus.instr[GRP_MSB:GRP_LSB];
  assign op = bus.instr[OP_MSB:OP_LSB];
  assign sub = bus.instr[SUB_MSB:SUB_LSB];
  assign bsel = bus.instr[BSEL_MSB:BSEL_LSB];
  assign lit = bus.instr[DATA_W-1:0];
  assign mask = BYTE_ONE << bsel;
  assign src = (grp == GRP_LIT) ? lit : bus.fileVal;
  // subtraction is a plus not-b plus one, so carry means no borrow
  assign isSub = (grp == GRP_LIT) ? !bus.instr[ADD_BIT] : (op == OP_SUB);
  assign addB = isSub ? ~bus.acc : bus.acc;
  assign sum = {1'b0, src} + {1'b0, addB} + {8'h00, isSub};
  assign half = {1'b0, src[3:0]} + {1'b0, addB[3:0]} + {4'h0, isSub};

  always_comb begin
    bus.result = BYTE_ZERO;
    bus.toAcc = 1'b0;
    bus.toFile = 1'b0;
    bus.setC = 1'b0;
    bus.newC = sum[DATA_W];
    bus.setDc = 1'b0;
    bus.newDc = half[4];
    bus.setZ = 1'b0;
    bus.skip = 1'b0;
    bus.jump = 1'b0;
    bus.call = 1'b0;
    bus.ret = 1'b0;
    bus.retIrq = 1'b0;
    bus.wdtClr = 1'b0;
    bus.sleep = 1'b0;
    case (grp)
      GRP_BYTE: begin
        bus.toAcc = !bus.instr[DEST_BIT];
        bus.toFile = bus.instr[DEST_BIT];
        bus.setZ = 1'b1;
        case (op)
          OP_CTRL: begin
            bus.result = bus.acc;
            bus.toAcc = 1'b0;
            bus.setZ = 1'b0;
            bus.ret = (lit == CTL_RET) || (lit == CTL_RETIRQ);
            bus.retIrq = (lit == CTL_RETIRQ);
            bus.wdtClr = (lit == CTL_WDT);
            bus.sleep = (lit == CTL_SLEEP);
          end
          OP_ZERO: bus.result = BYTE_ZERO;
          OP_SUB, OP_ADD: begin
            bus.result = sum[DATA_W-1:0];
            bus.setC = 1'b1;
            bus.setDc = 1'b1;
          end
          OP_DEC: bus.result = bus.fileVal - BYTE_ONE;
          OP_OR: bus.result = bus.fileVal | bus.acc;
          OP_AND: bus.result = bus.fileVal & bus.acc;
          OP_XOR: bus.result = bus.fileVal ^ bus.acc;
          OP_MOVE: bus.result = bus.fileVal;
          OP_INV: bus.result = ~bus.fileVal;
          OP_INC: bus.result = bus.fileVal + BYTE_ONE;
          OP_DECSZ, OP_INCSZ: begin
            bus.setZ = 1'b0;
            bus.result = (op == OP_INCSZ) ? bus.fileVal + BYTE_ONE : bus.fileVal - BYTE_ONE;
            bus.skip = (op == OP_INCSZ) ? (bus.fileVal == BYTE_FULL)
                                        : (bus.fileVal == BYTE_ONE);
          end
          OP_RRC, OP_RLC: begin
            bus.setZ = 1'b0;
            bus.setC = 1'b1;
            bus.newC = (op == OP_RLC) ? bus.fileVal[DATA_W-1] : bus.fileVal[0];
            bus.result = (op == OP_RLC) ? {bus.fileVal[DATA_W-2:0], bus.carryIn}
                                        : {bus.carryIn, bus.fileVal[DATA_W-1:1]};
          end
          default: begin
            bus.setZ = 1'b0;
            bus.result = {bus.fileVal[3:0], bus.fileVal[7:4]};
          end
        endcase
      end
      GRP_BIT: begin
        bus.result = (sub == BIT_CLR) ? (bus.fileVal & ~mask) : (bus.fileVal | mask);
        bus.toFile = (sub == BIT_CLR) || (sub == BIT_SET);
        bus.skip = (sub == BIT_TSTC) ? !bus.fileVal[bsel] :
                   (sub != BIT_SET) && (sub != BIT_CLR) && bus.fileVal[bsel];
      end
      GRP_JUMP: begin
        bus.jump = 1'b1;
        bus.call = !bus.instr[CALL_BIT];
      end
      default: begin
        bus.toAcc = 1'b1;
        bus.result = lit;
        bus.ret = (sub == LIT_RET);
        if (sub == LIT_LOGIC) begin
          bus.setZ = 1'b1;
          case (bus.instr[SEL_MSB:SEL_LSB])
            LOG_OR: bus.result = bus.acc | lit;
            LOG_AND: bus.result = bus.acc & lit;
            LOG_XOR: bus.result = bus.acc ^ lit;
            default: begin
              bus.toAcc = 1'b0;
              bus.setZ = 1'b0;
            end
          endcase
        end else if (sub != LIT_LOAD && sub != LIT_RET) begin
          bus.result = sum[DATA_W-1:0];
          bus.setC = 1'b1;
          bus.setDc = 1'b1;
          bus.setZ = 1'b1;
        end
      end
    endcase
  end
endmodule
`default_nettype wire

// ### fbd_pkg.sv
// shared constants and types for the fourteen-bit instruction decoder
// Contract
// - instruction words are 14 bits: an operation code and operand fields.
// - byte operations send the result to acc when d is 0, file when 1.
// - the file address operand is 7 bits, registers 0x00 to 0x7F.
// - a 3-bit operand selects one of eight bits in the addressed register.
// - literals are 8 bits; call 100 and jump 101 carry 11-bit targets.
// - one instruction cycle is four oscillator periods; ordinary ops finish in it.
// - taken tests and program counter changes add a second, no-operation cycle.
// - file operations read the register, modify, then write the destination.
// - don't-care encoding bits are ignored whatever their value.
// - byte group 00; field 0111 adds, 0010 subtracts acc; both update C, DC, Z.
// - byte fields 0100, 0110, 0101 do OR, XOR, AND with zero flag only.
// - byte fields 1101 and 1100 rotate left or right through carry only.
// - fields 1011 and 1111 decrement or increment, skip on zero, flags untouched.
// - bit group 01: clear, set, skip if clear, skip if set; no flags.
// - literal fields 1000, 1010, 1001 OR, XOR, AND into acc, zero flag only.
// - literal 111x adds, 110x subtracts acc from literal; update C, DC, Z.
// - control words ending 1000 and 1001 return from call and interrupt, two cycles.
// - return with literal loads acc and returns, taking two cycles.
// - low byte 0110 0100 clears the watchdog and updates timeout and powerdown bits.
// - low byte 0110 0011 enters standby, updating timeout and powerdown bits.
// - the read part of an io port access samples pins, not the latch.
// - an instruction write to the timer count clears its assigned prescaler.
package fbd_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int JUMP_W = 11;
  localparam int PC_W = JUMP_W;
  localparam int PSC_W = 8;
  localparam int CTRL_W = 2;
  localparam int FILE_DEPTH = 128;
  localparam int STAT_W = 7;
  // instruction field positions
  localparam int GRP_MSB = 13;
  localparam int GRP_LSB = 12;
  localparam int OP_MSB = 11;
  localparam int OP_LSB = 8;
  localparam int SUB_MSB = 11;
  localparam int SUB_LSB = 10;
  localparam int SEL_MSB = 9;
  localparam int SEL_LSB = 8;
  localparam int BSEL_MSB = 9;
  localparam int BSEL_LSB = 7;
  localparam int DEST_BIT = 7;
  localparam int CALL_BIT = 11;
  localparam int ADD_BIT = 9;
  // encodings
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;
  localparam logic [3:0] OP_CTRL = 4'h0;
  localparam logic [3:0] OP_ZERO = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOVE = 4'h8;
  localparam logic [3:0] OP_INV = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RRC = 4'hC;
  localparam logic [3:0] OP_RLC = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;
  localparam logic [7:0] CTL_RET = 8'h08;
  localparam logic [7:0] CTL_RETIRQ = 8'h09;
  localparam logic [7:0] CTL_WDT = 8'h64;
  localparam logic [7:0] CTL_SLEEP = 8'h63;
  localparam logic [1:0] BIT_CLR = 2'h0;
  localparam logic [1:0] BIT_SET = 2'h1;
  localparam logic [1:0] BIT_TSTC = 2'h2;
  localparam logic [1:0] LIT_LOAD = 2'h0;
  localparam logic [1:0] LIT_RET = 2'h1;
  localparam logic [1:0] LIT_LOGIC = 2'h2;
  localparam logic [1:0] LOG_OR = 2'h0;
  localparam logic [1:0] LOG_AND = 2'h1;
  localparam logic [1:0] LOG_XOR = 2'h2;
  localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_FULL = 8'hFF;
  // file addresses with side effects
  localparam logic [FADDR_W-1:0] FA_TIMER = 7'h01;
  localparam logic [FADDR_W-1:0] FA_PORT = 7'h05;
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0C;
  localparam logic [7:0] REG_TIMER = 8'h10;
  localparam logic [7:0] REG_INSTR = 8'h14;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PSA = 1;
  localparam int CTRL_WAKE = 2;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_TO = 3;
  localparam int ST_PD = 4;
  localparam int ST_STBY = 5;
  localparam int ST_IRQEN = 6;
  localparam int TMR_PSC_LSB = 8;
  // reset values and the prescaler maximum
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
  localparam logic [PSC_W-1:0] PSC_RST = 8'h00;
  localparam logic [PSC_W-1:0] PSC_MAX = 8'hFF;
  localparam logic STAT_TO_RST = 1'b1;
  localparam logic STAT_PD_RST = 1'b1;

  typedef enum logic [1:0] {PH_FETCH, PH_READ, PH_MODIFY, PH_WRITE} fbd_phase_type;
endpackage

// ### fbd_prog_mem.sv
// program memory model answering fetches with fourteen-bit words
`timescale 1ns/1ps
`default_nettype none
module fbd_prog_mem
  import fbd_pkg::*;
(
  // fetch side
  input wire logic [PC_W-1:0] addr,
  output logic [INSTR_W-1:0] word
);
  logic [INSTR_W-1:0] mem [0:(1<<PC_W)-1];
  // unloaded words decode as no-operation rather than unknowns
  initial begin
    for (int i = 0; i < (1 << PC_W); i++) mem[i] = NOP_WORD;
  end
  // combinational read: the core samples the word in its fetch phase
  assign word = mem[addr];
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench running short programs through the core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fbd_pkg::*;
  logic clk, rstn, read, write, waitrequest, wdtClear, standby;
  logic [7:0] address, portIn, portOut, k1, k2, pins, accE;
  logic [2:0] bs;
  logic [31:0] writedata, readdata, q;
  logic [PC_W-1:0] progAddr;
  logic [INSTR_W-1:0] progWord;
  int errors, checks, seed, n, wd;
  fbd_core i_fbd_core (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .progAddr(progAddr), .progWord(progWord), .portIn(portIn), .portOut(portOut),
    .wdtClear(wdtClear), .standby(standby));
  fbd_prog_mem i_fbd_prog_mem (.addr(progAddr), .word(progWord));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // acc after load and add, then an xor with ff unless the port bit test skips it
  function automatic logic [7:0] acc_exp(input logic [7:0] a, input logic [7:0] b,
    input logic pinSet);
    return pinSet ? 8'(a + b) : ~8'(a + b);
  endfunction
  // status after the program: timeout set, powerdown clear, standby set
  function automatic logic [31:0] stat_exp(input logic [7:0] a, input logic [7:0] b,
    input logic pinSet);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {26'h0, 6'h28} | {29'h0, acc_exp(a, b, pinSet) == 8'h00, h[4], s[8]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    wrap_up();
  end
  initial begin
    seed = 32'h55932153;
    errors = 0;
    checks = 0;
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    portIn = 8'h00;
    repeat (16) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      // first two passes hit the zero and carry corners, with the skip taken and not
      k1 = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      k2 = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : 8'($random(seed));
      pins = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
      bs = 3'($random(seed));
      accE = acc_exp(k1, k2, pins[bs]);
      i_fbd_prog_mem.mem[0] = 14'h2804;
      i_fbd_prog_mem.mem[1] = 14'h3EFF;
      i_fbd_prog_mem.mem[4] = {4'hC, 2'($random(seed)), k1};
      i_fbd_prog_mem.mem[5] = {5'h1F, 1'($random(seed)), k2};
      i_fbd_prog_mem.mem[6] = {4'h7, bs, FA_PORT};
      i_fbd_prog_mem.mem[7] = 14'h3AFF;
      i_fbd_prog_mem.mem[8] = {7'h01, FA_PORT};
      i_fbd_prog_mem.mem[9] = {7'h01, FA_TIMER};
      i_fbd_prog_mem.mem[10] = {6'h00, CTL_WDT};
      i_fbd_prog_mem.mem[11] = {6'h00, CTL_SLEEP};
      portIn <= pins;
      @(posedge clk);
      rstn <= 1'b1;
      bus(1'b1, REG_CTRL, 32'h3, q);
      wd = 0;
      for (n = 0; n < 200 && standby !== 1'b1; n++) begin
        @(posedge clk);
        wd += int'(wdtClear === 1'b1);
      end
      chk({31'h0, standby}, 32'h1);
      chk({21'h0, progAddr}, 32'hC);
      chk(32'(wd), 32'h1);
      chk({24'h0, portOut}, {24'h0, accE});
      bus(1'b1, REG_ACC, 32'h55, q);
      bus(1'b0, REG_ACC, 32'h0, q);
      chk(q, {24'h0, accE});
      bus(1'b0, REG_STAT, 32'h0, q);
      chk(q, stat_exp(k1, k2, pins[bs]));
      bus(1'b0, REG_PC, 32'h0, q);
      chk(q, 32'hC);
      bus(1'b0, REG_TIMER, 32'h0, q);
      chk(q, {16'h0, 8'h02, accE});
      bus(1'b0, 8'h18, 32'h0, q);
      chk(q, 32'h0);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
